//--- include/lrc_map.svh
`ifndef LRC_MAP_SVH
`define LRC_MAP_SVH

// ==========================================================
// Sequence numbering
`define SEQ_W 7
`define SEQ_ONE 7'h01
`define MAX_OUTSTANDING 7'h7f

// ==========================================================
// Indicator bits and flag spacing
`define CYCLIC_IND_VALUE 1'b1
`define FLAGS_SINGLE 2'h1
`define FLAGS_REPEAT 2'h2

// ==========================================================
// Timing: clock, microsecond tick and acknowledgement delay timer
`define CLK_PERIOD_PS 8000
`define TICK_NS 1000
`define TICK_CYCLES ((`TICK_NS * 1000) / `CLK_PERIOD_PS)
`define ACK_DELAY_US 1000000

// ==========================================================
// Reset values
`define RST_SEQ 7'h7f
`define RST_IND 1'b1

`endif

//--- include/lrc_pkg.sv
package lrc_pkg;

   // ==========================================================
   // Signal unit kinds on the transmit and receive paths
   typedef enum logic [1:0] {
      SU_FISU,
      SU_LSSU,
      SU_MSU
   } su_kind_e;

   typedef logic [6:0] seq_t;
   typedef logic [7:0] len_t;
   typedef logic [31:0] msg_t;

   // ==========================================================
   // Transmit scheduler modes
   typedef enum logic [1:0] {
      TXM_NORMAL,
      TXM_RETRANSMIT,
      TXM_FORCED
   } tx_mode_e;

   // ==========================================================
   // One unit handed to the framer
   typedef struct packed {
      su_kind_e kind;
      seq_t fsn;
      logic fib;
      seq_t bsn;
      logic bib;
      logic [1:0] flags;
      len_t len;
      msg_t msg;
   } tx_unit_s;

endpackage

//--- include/stream_if.sv
`timescale 1ns/10ps

// ==========================================================
// Valid/ready word stream between the scheduler and its buffer
interface stream_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src(output valid, output data, input ready);
   modport snk(input valid, input data, output ready);
endinterface

//--- design/tick_divider.sv
`timescale 1ns/10ps

module tick_divider #(
   parameter int DIV = 125
) (
   input wire logic clk_in, // System clock
   input wire logic rst_in, // Asynchronous reset, high
   output logic tick_out // One-cycle enable every DIV cycles
);
   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } div_s;

   localparam logic [15:0] LAST = 16'(DIV - 1);

   div_s st_ff;
   div_s nxt_st;

   if (DIV < 1 || DIV > 65536) begin : g_chk
      $error("tick_divider: DIV out of range");
   end

   // ==========================================================
   // Free-running count; the enable keeps all slow logic on one clock
   always_comb begin
      nxt_st = st_ff;
      nxt_st.tick = (st_ff.cnt == LAST);
      nxt_st.cnt = (st_ff.cnt == LAST) ? 16'h0000 : st_ff.cnt + 16'h0001;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tick_out = st_ff.tick;
endmodule

//--- design/two_entry_buffer.sv
`timescale 1ns/10ps

module two_entry_buffer #(
   parameter int WIDTH = 8
) (
   input wire logic clk_in, // System clock
   input wire logic rst_in, // Asynchronous reset, high
   stream_if.snk up, // Filling side
   stream_if.src dn // Draining side
);
   typedef struct packed {
      logic [1:0][WIDTH-1:0] slot;
      logic [1:0] cnt;
      logic wr;
      logic rd;
   } buf_s;

   buf_s st_ff;
   buf_s nxt_st;
   logic push;
   logic pop;

   if (WIDTH < 1) begin : g_chk
      $error("two_entry_buffer: WIDTH must be positive");
   end

   // ==========================================================
   // Honest full and empty; a stalled drain fills both slots
   assign up.ready = (st_ff.cnt != 2'h2);
   assign dn.valid = (st_ff.cnt != 2'h0);
   assign dn.data = st_ff.slot[st_ff.rd];
   assign push = up.valid && up.ready;
   assign pop = dn.valid && dn.ready;

   always_comb begin
      nxt_st = st_ff;
      if (push) begin
         nxt_st.slot[st_ff.wr] = up.data;
         nxt_st.wr = ~st_ff.wr;
      end
      if (pop) begin
         nxt_st.rd = ~st_ff.rd;
      end
      nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule

//--- design/link_retransmission_control.sv
`timescale 1ns/10ps
`include "lrc_map.svh"

module link_retransmission_control #(
   parameter int T7_TICKS = `ACK_DELAY_US, // Acknowledgement delay in microsecond ticks
   parameter int TICK_DIV = `TICK_CYCLES // Clock cycles per microsecond tick
) (
   input wire logic SYS_CLK_IN, // 125 MHz system clock
   input wire logic RESET_IN, // Asynchronous reset, high
   input wire logic CYCLIC_MODE_IN, // 1 selects cyclic method
   input wire logic REPEAT_EN_IN, // Basic method: send each new unit twice
   input wire logic [6:0] N1_LIMIT_IN, // Cyclic: outstanding unit limit
   input wire logic [15:0] N2_LIMIT_IN, // Cyclic: outstanding octet limit
   input wire logic NEW_VALID_IN, // New message unit waiting
   output logic NEW_READY_OUT, // New message unit taken
   input wire lrc_pkg::len_t NEW_LEN_IN, // New unit octet count
   input wire lrc_pkg::msg_t NEW_MSG_IN, // New unit payload handle
   input wire logic LSSU_PENDING_IN, // Link status unit waiting
   output logic LSSU_READY_OUT, // Link status unit slot taken
   input wire logic [6:0] ACK_BSN_IN, // Local receiver's acknowledgement number
   input wire logic NACK_REQ_IN, // Local receiver requests retransmission
   input wire logic RX_VALID_IN, // Received unit strobe
   input wire logic RX_CRC_OK_IN, // Polynomial check passed
   input wire lrc_pkg::su_kind_e RX_KIND_IN, // Received unit kind
   input wire logic [6:0] RX_BSN_IN, // Received backward number
   input wire logic RX_BIB_IN, // Received backward indicator
   input wire logic RX_FIB_IN, // Received forward indicator
   output logic RX_ACCEPT_OUT, // Received unit passed on
   output logic RX_DISCARD_OUT, // Received unit discarded
   output logic LINK_FAULT_OUT, // Two-in-three fault to level 3
   output logic ACK_DELAY_FAIL_OUT, // Acknowledgement timer expired
   output logic RETRANSMITTING_OUT, // Retransmission or forced cycle busy
   output logic [6:0] OUTSTANDING_OUT, // Units awaiting acknowledgement
   output logic [15:0] OCTETS_OUT, // Octets held for retransmission
   output logic TX_VALID_OUT, // Unit to framer valid
   input wire logic TX_READY_IN, // Framer takes unit
   output lrc_pkg::tx_unit_s TX_UNIT_OUT // Unit fields to framer
);
   import lrc_pkg::*;

   // ==========================================================
   // State
   typedef struct packed {
      tx_mode_e mode;
      seq_t last_fsn;
      seq_t ack_bsn;
      seq_t rel_bsn;
      logic [15:0] octets;
      seq_t ptr;
      logic tx_fib;
      logic tx_bib;
      logic nack_pend;
      logic disc_next;
      logic [2:0] bsn_hist;
      logic [2:0] fib_hist;
      logic [23:0] t7_cnt;
      logic rep_pend;
      seq_t rep_fsn;
      logic fault;
      logic t7_fail;
      logic rx_acc;
      logic rx_disc;
   } st_s;

   localparam logic [23:0] T7_LAST = 24'(T7_TICKS - 1);

   if (T7_TICKS < 1 || T7_TICKS > 16777216) begin : g_chk_t7
      $error("link_retransmission_control: T7_TICKS out of range");
   end

   st_s st_ff;
   st_s nxt_st;
   msg_t mem_msg [128];
   len_t mem_len [128];
   logic tick;
   logic go;
   logic wr_new;
   tx_unit_s unit;
   seq_t outstanding;
   seq_t held;
   logic rx_take;
   logic bsn_ok;
   logic fib_bad;
   logic discard;
   logic room_new;
   logic at_limit;
   seq_t first_fsn;
   seq_t eff_ptr;
   seq_t wrap_ptr;
   logic [15:0] rel_len;

   stream_if #(.W($bits(tx_unit_s))) up_if();
   stream_if #(.W($bits(tx_unit_s))) dn_if();

   // Microsecond enable for the timer, so the timeout is wall time
   tick_divider #(.DIV(TICK_DIV)) u_tick (
      .clk_in(SYS_CLK_IN),
      .rst_in(RESET_IN),
      .tick_out(tick)
   );

   // Decouples the scheduler from framer stalls without losing a unit
   two_entry_buffer #(.WIDTH($bits(tx_unit_s))) u_buf (
      .clk_in(SYS_CLK_IN),
      .rst_in(RESET_IN),
      .up(up_if),
      .dn(dn_if)
   );

   // ==========================================================
   // Window arithmetic, all modulo 128
   function automatic logic in_window(input seq_t x, input seq_t base, input seq_t cnt);
      seq_t d;
      d = x - base;
      return (d != 7'h00) && (d <= cnt);
   endfunction

   function automatic logic two_of_three(input logic [2:0] h);
      return (h[0] & h[1]) | (h[1] & h[2]) | (h[0] & h[2]);
   endfunction

   // Oldest unit still awaiting acknowledgement
   assign first_fsn = st_ff.ack_bsn + `SEQ_ONE;
   assign outstanding = st_ff.last_fsn - st_ff.ack_bsn;
   assign held = st_ff.last_fsn - st_ff.rel_bsn;
   assign eff_ptr = in_window(st_ff.ptr, st_ff.ack_bsn, outstanding) ? st_ff.ptr : first_fsn;
   assign wrap_ptr = (eff_ptr == st_ff.last_fsn) ? first_fsn : eff_ptr + `SEQ_ONE;
   assign rel_len = {8'h00, mem_len[st_ff.rel_bsn + `SEQ_ONE]};

   // Storage freed by releases may lag the window, so the slot limit uses held units
   assign room_new = (held < `MAX_OUTSTANDING)
      && (!CYCLIC_MODE_IN || ((outstanding < N1_LIMIT_IN) && (st_ff.octets < N2_LIMIT_IN)));
   assign at_limit = CYCLIC_MODE_IN && (outstanding != 7'h00)
      && ((outstanding >= N1_LIMIT_IN) || (st_ff.octets >= N2_LIMIT_IN));

   // ==========================================================
   // Receive-side checks on backward number and forward indicator
   assign rx_take = RX_VALID_IN && RX_CRC_OK_IN && (RX_KIND_IN != SU_LSSU);
   assign bsn_ok = (RX_BSN_IN == st_ff.ack_bsn) || in_window(RX_BSN_IN, st_ff.ack_bsn, outstanding);
   assign fib_bad = !CYCLIC_MODE_IN && (RX_FIB_IN != st_ff.tx_bib) && !st_ff.nack_pend;
   assign discard = !bsn_ok || fib_bad || st_ff.disc_next;

   // ==========================================================
   // Transmit selection, one unit per free buffer slot
   assign go = up_if.ready;
   assign up_if.valid = go;
   assign up_if.data = unit;

   always_comb begin
      unit = '0;
      unit.kind = SU_FISU;
      unit.fsn = st_ff.last_fsn;
      unit.bsn = ACK_BSN_IN;
      unit.fib = CYCLIC_MODE_IN ? `CYCLIC_IND_VALUE : st_ff.tx_fib;
      unit.bib = CYCLIC_MODE_IN ? `CYCLIC_IND_VALUE : st_ff.tx_bib;
      unit.flags = (REPEAT_EN_IN && !CYCLIC_MODE_IN) ? `FLAGS_REPEAT : `FLAGS_SINGLE;
      NEW_READY_OUT = 1'b0;
      LSSU_READY_OUT = 1'b0;
      wr_new = 1'b0;
      nxt_st = st_ff;
      nxt_st.fault = 1'b0;
      nxt_st.t7_fail = 1'b0;
      nxt_st.rx_acc = 1'b0;
      nxt_st.rx_disc = 1'b0;

      // Release one held entry per cycle up to the acknowledged number
      if (st_ff.rel_bsn != st_ff.ack_bsn) begin
         nxt_st.rel_bsn = st_ff.rel_bsn + `SEQ_ONE;
         nxt_st.octets = st_ff.octets - rel_len;
      end

      if (go) begin
         if (st_ff.mode != TXM_NORMAL) begin
            // Resend from the pointer; a pointer already released restarts the window
            if (outstanding == 7'h00) begin
               nxt_st.mode = TXM_NORMAL;
            end else begin
               unit.kind = SU_MSU;
               unit.fsn = eff_ptr;
               unit.msg = mem_msg[eff_ptr];
               unit.len = mem_len[eff_ptr];
               nxt_st.ptr = wrap_ptr;
               if (eff_ptr == st_ff.last_fsn) begin
                  // A forced pass starts over while either limit still stands
                  nxt_st.mode = (st_ff.mode == TXM_FORCED && at_limit) ? TXM_FORCED : TXM_NORMAL;
               end
            end
         end else if (at_limit) begin
            // Forced cycle: the oldest held unit goes at once, so no fill-in slips in
            nxt_st.mode = (first_fsn == st_ff.last_fsn) ? TXM_NORMAL : TXM_FORCED;
            unit.kind = SU_MSU;
            unit.fsn = first_fsn;
            unit.msg = mem_msg[first_fsn];
            unit.len = mem_len[first_fsn];
            nxt_st.ptr = first_fsn + `SEQ_ONE;
         end else if (st_ff.rep_pend && !CYCLIC_MODE_IN) begin
            nxt_st.rep_pend = 1'b0;
            if (in_window(st_ff.rep_fsn, st_ff.ack_bsn, outstanding)) begin
               unit.kind = SU_MSU;
               unit.fsn = st_ff.rep_fsn;
               unit.msg = mem_msg[st_ff.rep_fsn];
               unit.len = mem_len[st_ff.rep_fsn];
            end
         end else if (LSSU_PENDING_IN) begin
            unit.kind = SU_LSSU;
            LSSU_READY_OUT = 1'b1;
         end else if (NEW_VALID_IN && room_new) begin
            NEW_READY_OUT = 1'b1;
            wr_new = 1'b1;
            unit.kind = SU_MSU;
            unit.fsn = st_ff.last_fsn + `SEQ_ONE;
            unit.msg = NEW_MSG_IN;
            unit.len = NEW_LEN_IN;
            nxt_st.last_fsn = st_ff.last_fsn + `SEQ_ONE;
            nxt_st.octets = nxt_st.octets + {8'h00, NEW_LEN_IN};
            nxt_st.rep_pend = REPEAT_EN_IN && !CYCLIC_MODE_IN;
            nxt_st.rep_fsn = st_ff.last_fsn + `SEQ_ONE;
         end else if (CYCLIC_MODE_IN && (outstanding != 7'h00)) begin
            // Idle cycles carry preventive resends of the whole window
            unit.kind = SU_MSU;
            unit.fsn = eff_ptr;
            unit.msg = mem_msg[eff_ptr];
            unit.len = mem_len[eff_ptr];
            nxt_st.ptr = wrap_ptr;
         end
      end

      // Local receiver asks for retransmission by inverting our backward bit
      if (NACK_REQ_IN && !CYCLIC_MODE_IN) begin
         nxt_st.tx_bib = ~st_ff.tx_bib;
         nxt_st.nack_pend = 1'b1;
      end

      // Received unit: histories, discards, acknowledgement and retransmission start
      if (rx_take) begin
         nxt_st.bsn_hist = {st_ff.bsn_hist[1:0], !bsn_ok};
         nxt_st.fib_hist = {st_ff.fib_hist[1:0], fib_bad};
         if (two_of_three({st_ff.bsn_hist[1:0], !bsn_ok})
            || two_of_three({st_ff.fib_hist[1:0], fib_bad})) begin
            nxt_st.fault = 1'b1;
            nxt_st.bsn_hist = 3'h0;
            nxt_st.fib_hist = 3'h0;
         end
         nxt_st.disc_next = !bsn_ok || fib_bad;
         nxt_st.rx_disc = discard;
         nxt_st.rx_acc = !discard;
         if (!discard) begin
            if (RX_BSN_IN != st_ff.ack_bsn) begin
               nxt_st.ack_bsn = RX_BSN_IN;
               nxt_st.t7_cnt = 24'h000000;
            end
            // A repeated acknowledgement leaves the window untouched
            if (RX_FIB_IN == st_ff.tx_bib && !(NACK_REQ_IN && !CYCLIC_MODE_IN)) begin
               nxt_st.nack_pend = 1'b0;
            end
            if (!CYCLIC_MODE_IN && (RX_BIB_IN != st_ff.tx_fib)) begin
               nxt_st.tx_fib = ~st_ff.tx_fib;
               nxt_st.rep_pend = 1'b0;
               if (RX_BSN_IN != st_ff.last_fsn) begin
                  nxt_st.mode = TXM_RETRANSMIT;
                  nxt_st.ptr = RX_BSN_IN + `SEQ_ONE;
               end else begin
                  nxt_st.mode = TXM_NORMAL;
               end
            end
         end
      end

      // Acknowledgement delay timer on the microsecond enable
      if (outstanding == 7'h00) begin
         nxt_st.t7_cnt = 24'h000000;
      end else if (tick && !(rx_take && !discard && (RX_BSN_IN != st_ff.ack_bsn))) begin
         if (st_ff.t7_cnt == T7_LAST) begin
            nxt_st.t7_fail = 1'b1;
            nxt_st.t7_cnt = 24'h000000;
         end else begin
            nxt_st.t7_cnt = st_ff.t7_cnt + 24'h000001;
         end
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         st_ff <= '0;
         st_ff.mode <= TXM_NORMAL;
         st_ff.last_fsn <= `RST_SEQ;
         st_ff.ack_bsn <= `RST_SEQ;
         st_ff.rel_bsn <= `RST_SEQ;
         st_ff.ptr <= `RST_SEQ;
         st_ff.tx_fib <= `RST_IND;
         st_ff.tx_bib <= `RST_IND;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Held copies stay until released; no reset needed for storage
   always_ff @(posedge SYS_CLK_IN) begin
      if (wr_new) begin
         mem_msg[st_ff.last_fsn + `SEQ_ONE] <= NEW_MSG_IN;
         mem_len[st_ff.last_fsn + `SEQ_ONE] <= NEW_LEN_IN;
      end
   end

   // ==========================================================
   // Outputs
   assign RX_ACCEPT_OUT = st_ff.rx_acc;
   assign RX_DISCARD_OUT = st_ff.rx_disc;
   assign LINK_FAULT_OUT = st_ff.fault;
   assign ACK_DELAY_FAIL_OUT = st_ff.t7_fail;
   assign RETRANSMITTING_OUT = (st_ff.mode != TXM_NORMAL);
   assign OUTSTANDING_OUT = outstanding;
   assign OCTETS_OUT = st_ff.octets;
   assign TX_VALID_OUT = dn_if.valid;
   assign dn_if.ready = TX_READY_IN;
   assign TX_UNIT_OUT = dn_if.data;
endmodule

//--- testbench/lrc_chk.sv
`timescale 1ns/10ps

// ==========================================================
// Port-level checks
module lrc_chk
   import lrc_pkg::*;
(
   input wire logic SYS_CLK_IN, // Clock
   input wire logic RESET_IN, // Reset
   input wire logic CYCLIC_MODE_IN, // Method
   input wire logic NEW_VALID_IN, // New unit
   input wire logic NEW_READY_OUT, // Taken
   input wire logic RX_VALID_IN, // Rx strobe
   input wire logic RX_CRC_OK_IN, // Check ok
   input wire su_kind_e RX_KIND_IN, // Rx kind
   input wire logic RX_ACCEPT_OUT, // Accept
   input wire logic RX_DISCARD_OUT, // Discard
   input wire logic LINK_FAULT_OUT, // Fault
   input wire logic ACK_DELAY_FAIL_OUT, // Timer
   input wire logic RETRANSMITTING_OUT, // Resend busy
   input wire logic [6:0] OUTSTANDING_OUT, // Held
   input wire logic TX_VALID_OUT, // Tx valid
   input wire tx_unit_s TX_UNIT_OUT // Tx unit
);
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (RESET_IN);
   // LSSUs and failed checks get no answer at all
   wire take = RX_VALID_IN && RX_CRC_OK_IN && RX_KIND_IN != SU_LSSU;
   a_rx_answer: assert property (take |=> RX_ACCEPT_OUT ^ RX_DISCARD_OUT)
      else $error("received unit not answered");
   a_rx_quiet: assert property (!take |=> !(RX_ACCEPT_OUT || RX_DISCARD_OUT))
      else $error("answer without a unit");
   a_fault_discard: assert property (LINK_FAULT_OUT |-> RX_DISCARD_OUT)
      else $error("fault without discard");
   a_fsn_step: assert property (NEW_VALID_IN && NEW_READY_OUT && !RX_VALID_IN |=>
      OUTSTANDING_OUT == $past(OUTSTANDING_OUT) + 7'h01) else $error("held count off");
   a_window_cap: assert property (OUTSTANDING_OUT == 7'h7f |-> !NEW_READY_OUT)
      else $error("unit taken past window");
   a_retx_hold: assert property (RETRANSMITTING_OUT |-> !NEW_READY_OUT)
      else $error("new unit during resend");
   a_cyclic_ind: assert property (CYCLIC_MODE_IN && TX_VALID_OUT |-> TX_UNIT_OUT.fib && TX_UNIT_OUT.bib)
      else $error("indicator bits not 1");
   a_timer_owed: assert property (ACK_DELAY_FAIL_OUT |-> $past(OUTSTANDING_OUT) != 7'h00)
      else $error("timer fired with nothing held");
   c_retx: cover property ($rose(RETRANSMITTING_OUT));
   c_fault: cover property (LINK_FAULT_OUT);
   c_timer: cover property (ACK_DELAY_FAIL_OUT);
endmodule

bind link_retransmission_control lrc_chk i_lrc_chk (.*);

//--- testbench/remote_terminal.sv
`timescale 1ns/10ps

// ==========================================================
// Far end: takes units promptly, every other cycle, or stalls
module remote_terminal (
   input wire logic clk_in, // Clock
   input wire logic rst_in, // Reset
   input wire logic stall_in, // Hold off
   input wire logic slow_in, // Half rate
   output logic ready_out // Takes unit
);
   logic tog_ff;
   // Toggle gives the slow pace
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) tog_ff <= 1'b0;
      else tog_ff <= ~tog_ff;
   end
   assign ready_out = !stall_in && (!slow_in || tog_ff);
endmodule

//--- testbench/test_link_retransmission_control.sv
`timescale 1ns/10ps

// ==========================================================
// Bench
module test_link_retransmission_control;
   import lrc_pkg::*;
   logic SYS_CLK_IN = 0, RESET_IN = 1, CYCLIC_MODE_IN = 0, REPEAT_EN_IN = 0, NEW_VALID_IN = 0;
   logic LSSU_PENDING_IN = 0, NACK_REQ_IN = 0, RX_VALID_IN = 0, RX_CRC_OK_IN = 1, RX_BIB_IN, RX_FIB_IN;
   logic NEW_READY_OUT, LSSU_READY_OUT, RX_ACCEPT_OUT, RX_DISCARD_OUT, LINK_FAULT_OUT, stall = 0, slow = 0;
   logic ACK_DELAY_FAIL_OUT, RETRANSMITTING_OUT, TX_VALID_OUT, TX_READY_IN;
   logic [6:0] N1_LIMIT_IN = 7'h02, ACK_BSN_IN = 7'h2a, RX_BSN_IN, OUTSTANDING_OUT;
   logic [15:0] N2_LIMIT_IN = 16'hffff, OCTETS_OUT;
   len_t NEW_LEN_IN = 8'h04;
   msg_t NEW_MSG_IN = 32'h0000_00a5;
   su_kind_e RX_KIND_IN = SU_FISU;
   tx_unit_s TX_UNIT_OUT;
   tx_unit_s log[$], m[$];
   logic [3:0] ans;
   int err_total = 0, checks_done = 0, k;

   link_retransmission_control #(.T7_TICKS(20), .TICK_DIV(2)) i_link_retransmission_control (.*);
   remote_terminal i_remote_terminal (.clk_in(SYS_CLK_IN), .rst_in(RESET_IN), .stall_in(stall),
      .slow_in(slow), .ready_out(TX_READY_IN));

   // 125 MHz
   always #4 SYS_CLK_IN = ~SYS_CLK_IN;
   // Record every unit the far end takes
   always @(posedge SYS_CLK_IN) begin
      if (TX_VALID_OUT && TX_READY_IN) log.push_back(TX_UNIT_OUT);
   end

   task automatic tick(input int n);
      repeat (n) @(posedge SYS_CLK_IN);
      #1;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         err_total++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // Received unit; ans = {accept, discard, fault, resending}
   task automatic rx(input logic [6:0] b, input logic bi, input logic fi);
      RX_BSN_IN = b;
      RX_BIB_IN = bi;
      RX_FIB_IN = fi;
      RX_VALID_IN = 1;
      tick(1);
      RX_VALID_IN = 0;
      ans = {RX_ACCEPT_OUT, RX_DISCARD_OUT, LINK_FAULT_OUT, RETRANSMITTING_OUT};
      tick(1);
   endtask
   // Ready is combinational, so it is read mid-cycle
   task automatic send(input int n);
      int c = 0;
      NEW_VALID_IN = 1;
      while (c < n) begin
         @(negedge SYS_CLK_IN);
         if (NEW_READY_OUT === 1'b1) c++;
         tick(1);
      end
      NEW_VALID_IN = 0;
   endtask
   // Message units seen since the last call
   task automatic grab();
      m = {};
      foreach (log[i]) if (log[i].kind == SU_MSU) m.push_back(log[i]);
      log = {};
   endtask
   task automatic final_report();
      $display("checks_done=%0d err_total=%0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (20000) @(posedge SYS_CLK_IN);
      err_total++;
      final_report();
   end

   // Main sequence
   initial begin
      tick(20);
      RESET_IN = 0;
      fork
         begin stall = 1; repeat (6) @(posedge SYS_CLK_IN); #1; stall = 0; end
         send(3);
      join
      tick(4);
      chk(OUTSTANDING_OUT, 3);
      grab();
      chk(m[0].fsn, 0);
      chk(m[2].fsn, 2);
      rx(0, 1, 1); chk(ans, 4'h8); chk(OUTSTANDING_OUT, 2);
      rx(0, 1, 1); chk(OUTSTANDING_OUT, 2);
      rx(2, 1, 1); chk(OUTSTANDING_OUT, 0);
      RX_CRC_OK_IN = 0;
      rx(9, 1, 1); chk(ans, 4'h0);
      RX_CRC_OK_IN = 1;
      slow = 1;
      send(3);
      slow = 0;
      rx(9, 1, 1); chk(ans, 4'h4);
      rx(2, 1, 1); chk(ans, 4'h4);
      rx(9, 1, 1); chk(ans, 4'h6);
      rx(2, 1, 1); chk(ans, 4'h4); chk(OUTSTANDING_OUT, 3);
      // Inverted backward bit: fsn 4 and 5 go again
      tick(4);
      log = {};
      rx(3, 0, 1); chk(ans, 4'h9);
      tick(8);
      grab();
      chk(m[0].fsn, 4); chk(m[1].fsn, 5);
      chk(m[0].fib, 0);
      chk(RETRANSMITTING_OUT, 0);
      // Unexpected forward bit change
      rx(3, 0, 0); chk(ans, 4'h4);
      rx(3, 0, 0); chk(ans, 4'h6);
      rx(3, 0, 1); chk(ans, 4'h4);
      NACK_REQ_IN = 1;
      tick(1);
      NACK_REQ_IN = 0;
      tick(4);
      chk(TX_UNIT_OUT.bib, 0);
      rx(3, 0, 0); chk(ans, 4'h8);
      // Timer restarts on a fresh ack, 20 ticks of 2 cycles
      rx(4, 0, 0);
      k = 0;
      while (ACK_DELAY_FAIL_OUT !== 1'b1 && k < 100) begin tick(1); k++; end
      chk(k >= 36 && k <= 44, 1);
      rx(5, 0, 0); chk(ans, 4'h8);
      LSSU_PENDING_IN = 1;
      tick(1);
      chk(LSSU_READY_OUT, 1);
      LSSU_PENDING_IN = 0;
      // Repetition: fsn 6 goes out twice with two flags
      REPEAT_EN_IN = 1;
      tick(4);
      log = {};
      send(1);
      tick(6);
      grab();
      REPEAT_EN_IN = 0;
      chk(m.size(), 2);
      chk(m[1].fsn, 6);
      chk(m[1].flags, 2);
      chk(OCTETS_OUT, 4);
      rx(6, 0, 0); chk(OCTETS_OUT, 0);
      send(127);
      tick(4);
      chk(OUTSTANDING_OUT, 127);
      NEW_VALID_IN = 1;
      tick(3);
      chk(NEW_READY_OUT, 0);
      NEW_VALID_IN = 0;
      // Cyclic method after a second reset, unit limit 2
      CYCLIC_MODE_IN = 1;
      RESET_IN = 1;
      tick(20);
      RESET_IN = 0;
      log = {};
      send(1);
      tick(8);
      grab();
      chk(m.size() > 3, 1);
      chk(m[2].fsn, 0);
      chk(m[2].fib & m[2].bib, 1);
      // Second unit reaches the unit limit of 2: forced cycle
      send(1);
      NEW_VALID_IN = 1;
      tick(2);
      chk(NEW_READY_OUT, 0);
      chk(RETRANSMITTING_OUT, 1);
      NEW_VALID_IN = 0;
      log = {};
      tick(6);
      k = 0;
      foreach (log[i]) if (log[i].kind != SU_MSU) k++;
      chk(k, 0);
      chk(log.size() > 3, 1);
      rx(1, 1, 1); chk(OUTSTANDING_OUT, 0);
      tick(6);
      chk(RETRANSMITTING_OUT, 0);
      log = {};
      tick(4);
      chk(log[0].kind, SU_FISU);
      final_report();
   end
endmodule
